/* tmte_pkg.sv */
// =====================================================================
// Shared constants and types for the station table engine
// =====================================================================
package tmte_pkg;

  // =====================================================================
  // Table geometry
  // =====================================================================
  localparam int ROW_W = 11;             // Row index width, 2048 rows
  localparam int BKT_W = 2;              // Bucket index width, 4 buckets
  localparam int IDX_W = ROW_W + BKT_W;  // Flat entry index width
  localparam int ENTRIES = 8192;         // Total table entries
  localparam int BUCKETS = 4;            // Buckets per row
  localparam int MAC_W = 48;             // Station address width
  localparam int VID_W = 12;             // VLAN width
  localparam int KEY_W = VID_W + MAC_W;  // Search key, VLAN on top
  localparam int PORTS = 26;             // Destination port set width
  localparam int MASKS = 64;             // Destination mask table depth
  localparam int MIDX_W = 6;             // Destination mask index width

  // =====================================================================
  // Entry kinds and multicast prefixes
  // =====================================================================
  localparam logic [1:0] KIND_AGING = 2'h0;   // Normal, subject to aging
  localparam logic [1:0] KIND_LOCKED = 2'h1;  // Normal, never ages
  localparam logic [1:0] KIND_V4MC = 2'h2;    // IPv4 multicast
  localparam logic [1:0] KIND_V6MC = 2'h3;    // IPv6 multicast
  localparam logic [23:0] V4_PREFIX = 24'h01005e;
  localparam logic [15:0] V6_PREFIX = 16'h3333;

  // =====================================================================
  // Periodic scan timing
  // =====================================================================
  localparam int CLK_NS = 40;            // Clock period in ns
  localparam int TICK_NS = 1000;         // Scan period unit, 1 us
  localparam int TICK_CYC = (TICK_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [4:0] TICK_LAST = 5'(TICK_CYC - 1);

  // =====================================================================
  // Command field
  // =====================================================================
  typedef enum logic [2:0] {
    CMD_IDLE, CMD_LEARN, CMD_UNLEARN, CMD_AGE,
    CMD_GET_NEXT, CMD_INIT, CMD_READ, CMD_WRITE
  } tmte_cmd_e;

  // Per-entry flags and pointers
  typedef struct packed {
    logic valid;
    logic [5:0] dest_mask_index;
    logic [2:0] v6_partial_port_mask;
    logic [1:0] kind;
    logic aged;
    logic cpu_copy;
    logic src_kill;
    logic ignore_vlan;
  } tmte_access_s;

  // Full entry, key in the low bits
  typedef struct packed {
    tmte_access_s acc;
    logic [11:0] vid;
    logic [47:0] mac;
  } tmte_entry_s;

  // Row hash; only the low 24 address bits take part so that
  // multicast entries land on the row their frames hash to
  function automatic logic [10:0] tmte_hash(input logic [47:0] mac, input logic [11:0] vid);
    tmte_hash = mac[10:0] ^ mac[21:11] ^ {9'h000, mac[23:22]} ^ vid[10:0] ^ {10'h000, vid[11]};
  endfunction

endpackage

/* tmte_engine.sv */
// What this block does
// - Age scan on command or periodic timer
// - Scan deletes aged entries of aging kind
// - Scan marks unaged entries of kinds 0, 1 as aged
// - Matching source frame clears aged flag
// - Command field returns idle when done
// - Learn inserts entry at hashed row
// - Unlearn_command deletes entry matching address, VLAN
// - Direct read returns entry at row, bucket
// - Lookup reports hit in valid, returns fields
// - Write stores entry at exact position
// - Find-next returns smallest larger valid key
// - Written entries accept arbitrary field contents
// - Kind 2 matches IPv4 multicast prefix
// - Kind 2 ports from address, index
// - Kind 3 matches IPv6 multicast prefix
// - Kind 3 ports from aged, mask, index, address
// - 2048 rows of four buckets, hashed
// - Two-bit kind; kinds 1-3 never age
// - Kinds 0, 1 use destination mask table
module tmte_engine (
  // Clock and reset
  input wire logic REF_CLK_I,
  input wire logic RST_I,
  // Software command and preload
  input wire logic CMD_WR_I,
  input wire tmte_pkg::tmte_cmd_e CMD_I,
  input wire logic [27:0] STATION_HIGH_I,
  input wire logic [31:0] STATION_LOW_I,
  input wire tmte_pkg::tmte_access_s ACCESS_I,
  input wire logic [10:0] POS_ROW_I,
  input wire logic [1:0] POS_BUCKET_I,
  input wire logic [19:0] PERIODIC_SCAN_PERIOD_I,
  // Command state and results
  output tmte_pkg::tmte_cmd_e TABLE_COMMAND_O,
  output logic [27:0] STATION_HIGH_O,
  output logic [31:0] STATION_LOW_O,
  output tmte_pkg::tmte_access_s ACCESS_O,
  // Destination mask table programming
  input wire logic MASK_WR_I,
  input wire logic [5:0] MASK_IDX_I,
  input wire logic [25:0] MASK_DATA_I,
  // Source station activity from the frame analyzer
  input wire logic SRC_VALID_I,
  input wire logic [47:0] SRC_MAC_I,
  input wire logic [11:0] SRC_VID_I,
  // Destination lookup request
  input wire logic DST_VALID_I,
  input wire logic [47:0] DST_MAC_I,
  input wire logic [11:0] DST_VID_I,
  input wire logic DST_IS_V4_I,
  input wire logic DST_IS_V6_I,
  // Destination lookup answer
  output logic DEST_VALID_O,
  output logic DEST_HIT_O,
  output logic [25:0] DEST_PORTS_O
);

  // =====================================================================
  // Storage
  // =====================================================================
  typedef enum logic {ENG_IDLE, ENG_RUN} tmte_state_e;

  tmte_pkg::tmte_entry_s mem [0:tmte_pkg::ENTRIES-1];   // Station table
  logic [25:0] dest_mask_table [0:tmte_pkg::MASKS-1];   // Port sets

  tmte_state_e state_r;                 // Engine state
  tmte_pkg::tmte_cmd_e cmd_r;           // Command field
  logic [59:0] key_r;                   // Preloaded VLAN and address
  tmte_pkg::tmte_access_s acc_r;        // Preloaded flags
  logic [12:0] pos_r;                   // Preloaded row and bucket
  logic [12:0] idx_r;                   // Walk index for full passes
  tmte_pkg::tmte_entry_s best_r;        // Find-next best so far
  logic found_r;                        // Find-next has a candidate
  logic pend_r;                         // Periodic scan owed
  logic [4:0] tick_r;                   // Microsecond prescaler
  logic [19:0] per_r;                   // Microseconds since last scan

  // =====================================================================
  // Source activity: clear aged flag on a matching entry
  // =====================================================================
  logic [10:0] src_row;
  tmte_pkg::tmte_entry_s src_ent [0:3];
  logic [3:0] src_match;
  logic src_we;
  logic [1:0] src_bkt;
  tmte_pkg::tmte_entry_s src_data;

  assign src_row = tmte_pkg::tmte_hash(SRC_MAC_I, SRC_VID_I);

  // Row reads for frame and engine paths, one per bucket
  logic [10:0] row_hash;
  tmte_pkg::tmte_entry_s row_ent [0:3];
  logic [3:0] row_hit;
  logic [3:0] row_free;
  logic [10:0] dst_row;
  tmte_pkg::tmte_entry_s dst_ent [0:3];
  logic [3:0] dst_match;

  assign row_hash = tmte_pkg::tmte_hash(key_r[47:0], key_r[59:48]);
  assign dst_row = tmte_pkg::tmte_hash(DST_MAC_I, DST_VID_I);

  for (genvar b = 0; b < tmte_pkg::BUCKETS; b++) begin : g_bkt
    assign src_ent[b] = mem[{src_row, 2'(b)}];
    // Only unicast kinds are ever a frame source
    assign src_match[b] = src_ent[b].acc.valid && src_ent[b].acc.aged &&
                          (src_ent[b].acc.kind <= tmte_pkg::KIND_LOCKED) &&
                          src_ent[b].mac == SRC_MAC_I && src_ent[b].vid == SRC_VID_I;
    assign row_ent[b] = mem[{row_hash, 2'(b)}];
    assign row_hit[b] = row_ent[b].acc.valid && {row_ent[b].vid, row_ent[b].mac} == key_r;
    assign row_free[b] = !row_ent[b].acc.valid;
    assign dst_ent[b] = mem[{dst_row, 2'(b)}];
    // Unicast kinds match on the full key, multicast kinds on VLAN, prefix and low address bits
    assign dst_match[b] = dst_ent[b].acc.valid && dst_ent[b].vid == DST_VID_I && (
      (dst_ent[b].acc.kind <= tmte_pkg::KIND_LOCKED && dst_ent[b].mac == DST_MAC_I) ||
      (dst_ent[b].acc.kind == tmte_pkg::KIND_V4MC && DST_IS_V4_I &&
       DST_MAC_I[47:24] == tmte_pkg::V4_PREFIX &&
       dst_ent[b].mac[23:0] == DST_MAC_I[23:0]) ||
      (dst_ent[b].acc.kind == tmte_pkg::KIND_V6MC && DST_IS_V6_I &&
       DST_MAC_I[47:32] == tmte_pkg::V6_PREFIX &&
       dst_ent[b].mac[31:0] == DST_MAC_I[31:0]));
  end

  // Priority encoders over the four buckets, lowest bucket first
  logic hit_any;
  logic [1:0] hit_bkt;
  logic free_any;
  logic [1:0] free_bkt;
  logic dst_any;
  tmte_pkg::tmte_entry_s dst_sel;

  always_comb begin
    hit_any = 1'b0;
    hit_bkt = 2'h0;
    free_any = 1'b0;
    free_bkt = 2'h0;
    dst_any = 1'b0;
    dst_sel = dst_ent[0];
    src_bkt = 2'h0;
    for (int i = tmte_pkg::BUCKETS - 1; i >= 0; i--) begin
      if (row_hit[i]) begin
        hit_any = 1'b1;
        hit_bkt = 2'(i);
      end
      if (row_free[i]) begin
        free_any = 1'b1;
        free_bkt = 2'(i);
      end
      if (dst_match[i]) begin
        dst_any = 1'b1;
        dst_sel = dst_ent[i];
      end
      if (src_match[i]) begin
        src_bkt = 2'(i);
      end
    end
  end

  // Frame activity owns the write port; the engine waits a cycle
  assign src_we = SRC_VALID_I && (src_match != 4'h0);
  assign src_data = '{acc: '{valid: 1'b1,
                             dest_mask_index: src_ent[src_bkt].acc.dest_mask_index,
                             v6_partial_port_mask: src_ent[src_bkt].acc.v6_partial_port_mask,
                             kind: src_ent[src_bkt].acc.kind,
                             aged: 1'b0,
                             cpu_copy: src_ent[src_bkt].acc.cpu_copy,
                             src_kill: src_ent[src_bkt].acc.src_kill,
                             ignore_vlan: src_ent[src_bkt].acc.ignore_vlan},
                      vid: src_ent[src_bkt].vid,
                      mac: src_ent[src_bkt].mac};

  // =====================================================================
  // Command engine decode
  // =====================================================================
  logic eng_go;                         // Engine may act this cycle
  logic sw_start;                       // Accepted software command
  logic auto_start;                     // Periodic scan start
  logic walk;                           // Command walks all entries
  logic eng_last;                       // Last entry of a walk
  logic eng_done;                       // Command completes this cycle
  tmte_pkg::tmte_entry_s cur_ent;       // Entry under the walk index
  tmte_pkg::tmte_entry_s key_ent;       // Preloaded entry image
  tmte_pkg::tmte_entry_s dir_ent;       // Entry at preloaded position
  logic better;                         // Walk entry beats best so far
  tmte_pkg::tmte_entry_s cand;
  logic found_nxt;
  logic eng_we;
  logic [12:0] eng_addr;
  tmte_pkg::tmte_entry_s eng_data;

  assign eng_go = (state_r == ENG_RUN) && !src_we;
  // Busy writes are dropped here, not queued
  assign sw_start = (state_r == ENG_IDLE) && CMD_WR_I && (CMD_I != tmte_pkg::CMD_IDLE);
  assign auto_start = (state_r == ENG_IDLE) && !sw_start && pend_r;
  assign walk = (cmd_r == tmte_pkg::CMD_AGE) || (cmd_r == tmte_pkg::CMD_INIT) ||
                (cmd_r == tmte_pkg::CMD_GET_NEXT);
  assign eng_last = (idx_r == 13'h1fff);
  assign eng_done = eng_go && (!walk || eng_last);
  assign cur_ent = mem[idx_r];
  assign dir_ent = mem[pos_r];
  assign key_ent = {acc_r, key_r};
  // Strictly above the start key, below the best so far
  assign better = cur_ent.acc.valid && ({cur_ent.vid, cur_ent.mac} > key_r) &&
                  (!found_r || {cur_ent.vid, cur_ent.mac} < {best_r.vid, best_r.mac});
  assign cand = better ? cur_ent : best_r;
  assign found_nxt = found_r || better;

  // Table write selection per command
  always_comb begin
    eng_we = 1'b0;
    eng_addr = idx_r;
    eng_data = cur_ent;
    if (eng_go) begin
      unique case (cmd_r)
        tmte_pkg::CMD_LEARN: begin
          // Refresh an existing key, else take the first free bucket
          eng_we = hit_any || free_any;
          eng_addr = {row_hash, hit_any ? hit_bkt : free_bkt};
          eng_data = key_ent;
          eng_data.acc.valid = 1'b1;
        end
        tmte_pkg::CMD_UNLEARN: begin
          eng_we = hit_any;
          eng_addr = {row_hash, hit_bkt};
          eng_data = row_ent[hit_bkt];
          eng_data.acc.valid = 1'b0;
        end
        tmte_pkg::CMD_WRITE: begin
          // Any contents, at the exact position
          eng_we = 1'b1;
          eng_addr = pos_r;
          eng_data = key_ent;
        end
        tmte_pkg::CMD_AGE: begin
          if (cur_ent.acc.valid && cur_ent.acc.aged &&
              cur_ent.acc.kind == tmte_pkg::KIND_AGING) begin
            eng_we = 1'b1;
            eng_data.acc.valid = 1'b0;
          end else if (cur_ent.acc.valid && !cur_ent.acc.aged &&
                       cur_ent.acc.kind <= tmte_pkg::KIND_LOCKED) begin
            // Multicast kinds keep their flag, in kind 3 it is a port bit
            eng_we = 1'b1;
            eng_data.acc.aged = 1'b1;
          end
        end
        tmte_pkg::CMD_INIT: begin
          eng_we = 1'b1;
          eng_data = '0;
        end
        tmte_pkg::CMD_IDLE, tmte_pkg::CMD_READ, tmte_pkg::CMD_GET_NEXT: begin
          eng_we = 1'b0;
        end
      endcase
    end
  end

  // =====================================================================
  // Table and mask storage writes
  // =====================================================================
  // Array has no reset; the engine runs a clear pass out of reset
  always_ff @(posedge REF_CLK_I) begin
    if (src_we) begin
      mem[{src_row, src_bkt}] <= src_data;
    end else if (eng_we) begin
      mem[eng_addr] <= eng_data;
    end
  end

  // Software-programmed port sets
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      for (int i = 0; i < tmte_pkg::MASKS; i++) begin
        dest_mask_table[i] <= 26'h0000000;
      end
    end else if (MASK_WR_I) begin
      dest_mask_table[MASK_IDX_I] <= MASK_DATA_I;
    end
  end

  // =====================================================================
  // Periodic scan timer
  // =====================================================================
  logic us_tick;
  logic fire;

  assign us_tick = (tick_r == tmte_pkg::TICK_LAST);
  // Zero period disables the timer
  assign fire = us_tick && (PERIODIC_SCAN_PERIOD_I != 20'h00000) &&
                (per_r >= PERIODIC_SCAN_PERIOD_I - 20'h00001);

  // Prescaler and period counter; a new fire wins over consumption
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      tick_r <= 5'h00;
      per_r <= 20'h00000;
      pend_r <= 1'b0;
    end else begin
      tick_r <= us_tick ? 5'h00 : tick_r + 5'h01;
      per_r <= fire ? 20'h00000 : (us_tick ? per_r + 20'h00001 : per_r);
      pend_r <= fire || (pend_r && !auto_start);
    end
  end

  // =====================================================================
  // Engine sequencing
  // =====================================================================
  // Reset starts a clear pass so every valid bit is defined
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      state_r <= ENG_RUN;
      cmd_r <= tmte_pkg::CMD_INIT;
      key_r <= 60'h0;
      acc_r <= '0;
      pos_r <= 13'h0000;
      idx_r <= 13'h0000;
      best_r <= '0;
      found_r <= 1'b0;
    end else if (sw_start) begin
      state_r <= ENG_RUN;
      cmd_r <= CMD_I;
      key_r <= {STATION_HIGH_I, STATION_LOW_I};
      acc_r <= ACCESS_I;
      pos_r <= {POS_ROW_I, POS_BUCKET_I};
      idx_r <= 13'h0000;
      found_r <= 1'b0;
    end else if (auto_start) begin
      state_r <= ENG_RUN;
      cmd_r <= tmte_pkg::CMD_AGE;
      idx_r <= 13'h0000;
    end else if (eng_go) begin
      idx_r <= idx_r + 13'h0001;
      best_r <= cand;
      found_r <= found_nxt;
      if (eng_done) begin
        state_r <= ENG_IDLE;
        cmd_r <= tmte_pkg::CMD_IDLE;
      end
    end
  end

  // Result registers: only reads and find-next return data
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      STATION_HIGH_O <= 28'h0000000;
      STATION_LOW_O <= 32'h00000000;
      ACCESS_O <= '0;
    end else if (eng_go && cmd_r == tmte_pkg::CMD_READ) begin
      if (acc_r.valid) begin
        // Lookup: valid shows the hit
        {STATION_HIGH_O, STATION_LOW_O} <= key_r;
        ACCESS_O <= hit_any ? row_ent[hit_bkt].acc : '0;
      end else begin
        {STATION_HIGH_O, STATION_LOW_O} <= {dir_ent.vid, dir_ent.mac};
        ACCESS_O <= dir_ent.acc;
      end
    end else if (eng_go && eng_last && cmd_r == tmte_pkg::CMD_GET_NEXT) begin
      {STATION_HIGH_O, STATION_LOW_O} <= found_nxt ? {cand.vid, cand.mac} : key_r;
      ACCESS_O <= found_nxt ? cand.acc : '0;
    end
  end

  assign TABLE_COMMAND_O = cmd_r;

  // =====================================================================
  // Destination lookup
  // =====================================================================
  logic [25:0] dst_ports;

  // Multicast kinds carry the port set in the entry itself
  assign dst_ports = !dst_any ? 26'h0000000 :
    (dst_sel.acc.kind == tmte_pkg::KIND_V4MC) ?
      {dst_sel.acc.dest_mask_index[1:0], dst_sel.mac[47:24]} :
    (dst_sel.acc.kind == tmte_pkg::KIND_V6MC) ?
      {dst_sel.acc.aged, dst_sel.acc.v6_partial_port_mask,
       dst_sel.acc.dest_mask_index, dst_sel.mac[47:32]} :
      dest_mask_table[dst_sel.acc.dest_mask_index];

  // One answer per request, a cycle later
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      DEST_VALID_O <= 1'b0;
      DEST_HIT_O <= 1'b0;
      DEST_PORTS_O <= 26'h0000000;
    end else begin
      DEST_VALID_O <= DST_VALID_I;
      DEST_HIT_O <= DST_VALID_I && dst_any;
      DEST_PORTS_O <= DST_VALID_I ? dst_ports : 26'h0000000;
    end
  end

  // =====================================================================
  // Assertions
  // =====================================================================
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (RST_I);

  sequence s_issue_single;
    sw_start && (CMD_I == tmte_pkg::CMD_READ || CMD_I == tmte_pkg::CMD_WRITE);
  endsequence
  sequence s_engine_acts;
    eng_go;
  endsequence

  a_cmd_accept: assert property (sw_start |=> TABLE_COMMAND_O == $past(CMD_I))
    else $error("accepted command not shown in command field");
  a_single_done: assert property (s_issue_single ##1 s_engine_acts |=>
    TABLE_COMMAND_O == tmte_pkg::CMD_IDLE)
    else $error("single command did not return to idle");
  a_busy_ignore: assert property ((state_r == ENG_RUN && CMD_WR_I && !eng_done) |=>
    TABLE_COMMAND_O == $past(TABLE_COMMAND_O))
    else $error("command write taken while busy");
  a_auto_start: assert property ((auto_start && !RST_I) |=>
    TABLE_COMMAND_O == tmte_pkg::CMD_AGE && idx_r == 13'h0000)
    else $error("owed periodic scan did not start");
  a_scan_delete: assert property ((eng_go && cmd_r == tmte_pkg::CMD_AGE &&
    cur_ent.acc.valid && cur_ent.acc.aged && cur_ent.acc.kind == tmte_pkg::KIND_AGING)
    |=> !mem[$past(idx_r)].acc.valid)
    else $error("aged entry survived the scan");
  a_scan_mark: assert property ((eng_go && cmd_r == tmte_pkg::CMD_AGE &&
    cur_ent.acc.valid && !cur_ent.acc.aged && cur_ent.acc.kind == tmte_pkg::KIND_AGING)
    |=> mem[$past(idx_r)].acc.valid && mem[$past(idx_r)].acc.aged)
    else $error("scan did not mark entry aged");
  a_src_clear: assert property (src_we |=> !mem[$past({src_row, src_bkt})].acc.aged)
    else $error("source activity did not clear aged flag");
  a_write_exact: assert property ((eng_go && cmd_r == tmte_pkg::CMD_WRITE) |=>
    mem[$past(pos_r)] == $past(key_ent))
    else $error("write not stored at given position");
  a_init_clear: assert property ((eng_go && cmd_r == tmte_pkg::CMD_INIT) |=>
    !mem[$past(idx_r)].acc.valid)
    else $error("initialise left an entry valid");
  a_v4_ports: assert property ((DST_VALID_I && dst_any &&
    dst_sel.acc.kind == tmte_pkg::KIND_V4MC) |=> DEST_HIT_O &&
    DEST_PORTS_O[23:0] == $past(dst_sel.mac[47:24]))
    else $error("IPv4 multicast port set wrong");
  a_v6_ports: assert property ((DST_VALID_I && dst_any &&
    dst_sel.acc.kind == tmte_pkg::KIND_V6MC) |=>
    DEST_PORTS_O[25] == $past(dst_sel.acc.aged) && DEST_PORTS_O[15:0] == $past(dst_sel.mac[47:32]))
    else $error("IPv6 multicast port set wrong");

endmodule // tmte_engine

/* tb_top.sv */
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin error_cnt++; $display("MISMATCH %0t got %h want %h", $time, a, b); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  // ====================================================================
  // Stimulus and observed signals
  // ====================================================================
  logic REF_CLK_I = 0, RST_I = 1, CMD_WR_I = 0, MASK_WR_I = 0, SRC_VALID_I = 0, DST_VALID_I = 0;
  logic DST_IS_V4_I = 0, DST_IS_V6_I = 0, DEST_VALID_O, DEST_HIT_O;
  tmte_pkg::tmte_cmd_e CMD_I = tmte_pkg::CMD_IDLE, TABLE_COMMAND_O, prv = tmte_pkg::CMD_INIT;
  tmte_pkg::tmte_access_s ACCESS_I = '0, ACCESS_O;
  logic [27:0] STATION_HIGH_I = '0, STATION_HIGH_O;
  logic [31:0] STATION_LOW_I = '0, STATION_LOW_O;
  logic [10:0] POS_ROW_I = '0;
  logic [1:0] POS_BUCKET_I = '0;
  logic [19:0] PERIODIC_SCAN_PERIOD_I = '0;
  logic [5:0] MASK_IDX_I = '0, di;
  logic [25:0] MASK_DATA_I = '0, DEST_PORTS_O, md;
  logic [47:0] SRC_MAC_I = '0, DST_MAC_I = '0, m;
  logic [11:0] SRC_VID_I = '0, DST_VID_I = '0;
  logic [59:0] k0, k2, k3, kw; // Keys, VLAN on top
  logic [15:0] a0, a2, a3, aw;
  logic [12:0] p; // Row and bucket of the direct write
  logic [2:0] vm;
  logic [26:0] dq[$]; // Notes for destination answers
  logic [75:0] rq[$], e; // Notes for read results
  int error_cnt = 0, compares = 0, seed = 80417, n;
  tmte_engine dut (.*);
  // Free running 25 MHz clock
  initial forever #20 REF_CLK_I = ~REF_CLK_I;
  // ====================================================================
  // Monitor: oldest note against each answer
  // ====================================================================
  // Sampled at the falling edge, well clear of the launching edge
  always @(negedge REF_CLK_I) begin
    if (DEST_VALID_O === 1'b1) begin
      e = dq.size() ? 76'(dq.pop_front()) : 'x;
      `CHK({DEST_HIT_O, DEST_PORTS_O}, e[26:0])
    end
    if (TABLE_COMMAND_O === tmte_pkg::CMD_IDLE && prv inside {tmte_pkg::CMD_READ, tmte_pkg::CMD_GET_NEXT}) begin
      e = rq.size() ? rq.pop_front() : 'x;
      `CHK({STATION_HIGH_O, STATION_LOW_O, ACCESS_O}, e)
    end
    prv = TABLE_COMMAND_O;
  end
  // Bounded wait for the command field to go idle
  task wi;
    for (n = 0; n < 20000 && TABLE_COMMAND_O !== tmte_pkg::CMD_IDLE; n++) @(negedge REF_CLK_I);
    if (n >= 20000) error_cnt++;
  endtask
  // One command write, then wait for completion
  task cmd(input tmte_pkg::tmte_cmd_e c, input logic [59:0] k, input logic [15:0] a, input logic [12:0] q);
    @(negedge REF_CLK_I);
    CMD_WR_I = 1;
    CMD_I = c;
    {STATION_HIGH_I, STATION_LOW_I, ACCESS_I, POS_ROW_I, POS_BUCKET_I} = {k, a, q};
    @(negedge REF_CLK_I);
    CMD_WR_I = 0;
    wi();
  endtask
  // Keyed lookup; result station is the preload key
  task lk(input logic [59:0] k, input logic [15:0] x);
    rq.push_back({k, x});
    cmd(tmte_pkg::CMD_READ, k, 16'h8000, '0);
  endtask
  // Destination request of one cycle
  task dl(input logic [59:0] k, input logic [1:0] ip, input logic [26:0] x);
    dq.push_back(x);
    @(negedge REF_CLK_I);
    {DST_VALID_I, DST_VID_I, DST_MAC_I, DST_IS_V4_I, DST_IS_V6_I} = {1'b1, k, ip};
    @(negedge REF_CLK_I);
    DST_VALID_I = 0;
  endtask
  task end_of_test;
    `CHK(dq.size() + rq.size(), 0)
    $display("error_cnt %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Watchdog well beyond eight full table walks
  initial begin
    #3.5ms;
    error_cnt++;
    end_of_test();
  end
  // ====================================================================
  // Main sequence
  // ====================================================================
  initial begin
    repeat (16) @(negedge REF_CLK_I);
    RST_I = 0;
    `CHK(TABLE_COMMAND_O, tmte_pkg::CMD_INIT)
    wi();
    m = 48'({$random(seed), $random(seed)});
    {md, di, vm, p} = 48'({$random(seed), $random(seed)});
    p[1:0] = 2'h3; // Bucket 3 stays clear of learned entries
    k0 = {12'h00c, m};
    k2 = {12'h100, m};
    k3 = {12'h101, m};
    kw = {12'h800, m};
    a0 = {7'h45, 3'h0, tmte_pkg::KIND_AGING, 4'h0};
    a2 = {1'b1, di, 3'h0, tmte_pkg::KIND_V4MC, 4'h0};
    a3 = {1'b1, di, vm, tmte_pkg::KIND_V6MC, 4'h8};
    aw = {1'b1, 15'($random(seed))};
    @(negedge REF_CLK_I);
    {MASK_WR_I, MASK_IDX_I, MASK_DATA_I} = {7'h45, md};
    @(negedge REF_CLK_I);
    MASK_WR_I = 0;
    cmd(tmte_pkg::CMD_LEARN, k0, a0, '0);
    cmd(tmte_pkg::CMD_LEARN, k2, a2, '0);
    cmd(tmte_pkg::CMD_LEARN, k3, a3, '0);
    cmd(tmte_pkg::CMD_WRITE, kw, aw, p);
    dl(k0, 2'b00, {1'b1, md});
    dl({12'h100, tmte_pkg::V4_PREFIX, m[23:0]}, 2'b10, {1'b1, di[1:0], m[47:24]});
    dl({12'h101, tmte_pkg::V6_PREFIX, m[31:0]}, 2'b01, {2'b11, vm, di, m[47:32]});
    rq.push_back({kw, aw});
    cmd(tmte_pkg::CMD_READ, '0, '0, p);
    lk(k0, a0);
    rq.push_back({k0, a0});
    cmd(tmte_pkg::CMD_GET_NEXT, k0 - 60'h1, '0, '0);
    // Age scan, with a unlearn_command written while busy that must be dropped
    @(negedge REF_CLK_I);
    CMD_WR_I = 1;
    CMD_I = tmte_pkg::CMD_AGE;
    @(negedge REF_CLK_I);
    CMD_I = tmte_pkg::CMD_UNLEARN;
    {STATION_HIGH_I, STATION_LOW_I} = k0;
    @(negedge REF_CLK_I);
    CMD_WR_I = 0;
    `CHK(TABLE_COMMAND_O, tmte_pkg::CMD_AGE)
    wi();
    lk(k0, a0 | 16'h0008);
    @(negedge REF_CLK_I);
    {SRC_VALID_I, SRC_VID_I, SRC_MAC_I} = {1'b1, k0};
    @(negedge REF_CLK_I);
    SRC_VALID_I = 0;
    lk(k0, a0);
    cmd(tmte_pkg::CMD_AGE, '0, '0, '0);
    cmd(tmte_pkg::CMD_AGE, '0, '0, '0);
    lk(k0, '0);
    dl({12'h100, tmte_pkg::V4_PREFIX, m[23:0]}, 2'b10, {1'b1, di[1:0], m[47:24]});
    cmd(tmte_pkg::CMD_UNLEARN, k2, '0, '0);
    dl({12'h100, tmte_pkg::V4_PREFIX, m[23:0]}, 2'b10, '0);
    cmd(tmte_pkg::CMD_INIT, '0, '0, '0);
    lk(k3, '0);
    // Empty table: find-next misses and hands back the start key
    rq.push_back({k3, 16'h0000});
    cmd(tmte_pkg::CMD_GET_NEXT, k3, '0, '0);
    PERIODIC_SCAN_PERIOD_I = 20'h1;
    for (n = 0; n < 60 && TABLE_COMMAND_O !== tmte_pkg::CMD_AGE; n++) @(negedge REF_CLK_I);
    `CHK(TABLE_COMMAND_O, tmte_pkg::CMD_AGE)
    PERIODIC_SCAN_PERIOD_I = '0;
    wi();
    end_of_test();
  end
endmodule // tb_top
